/* lisc_pkg.sv */
// package: constants and carriers for the low-power input sense config block
package lisc_pkg;

  // channel counts
  localparam int LISC_GND_CH = 14;
  localparam int LISC_PROG_CH = 8;

  // spi frame layout
  localparam int LISC_FRAME_W = 32;
  localparam int LISC_ADDR_W = 7;
  localparam int LISC_DATA_W = 24;
  localparam int LISC_ADDR_MSB = 31;
  localparam int LISC_ADDR_LSB = 25;
  localparam int LISC_RW_BIT = 24;
  localparam int LISC_FAULT_BIT = 23;
  localparam int LISC_INT_BIT = 22;
  localparam int LISC_RDATA_W = 22;

  // register addresses
  localparam logic [6:0] LISC_ADDR_GND_CMP_ONLY = 7'h13;
  localparam logic [6:0] LISC_ADDR_PROG_LP_THR = 7'h14;
  localparam logic [6:0] LISC_ADDR_GND_LP_THR = 7'h15;
  localparam logic [6:0] LISC_ADDR_PROG_POLL_CUR = 7'h16;

  // reset values
  localparam logic [13:0] LISC_GND_RESET = 14'h0000;
  localparam logic [7:0] LISC_PROG_RESET = 8'h00;

  // threshold select encodings
  typedef enum logic [1:0] {
    LISC_THR_DELTA,
    LISC_THR_NORMAL,
    LISC_THR_FIXED_BATT
  } lisc_thr_e;

  // polling current select encodings
  typedef enum logic [1:0] {
    LISC_CUR_NONE,
    LISC_CUR_NORMAL,
    LISC_CUR_WETTING
  } lisc_cur_e;

  // per-channel low-power sense setting
  typedef struct packed {
    logic cmp_active;
    lisc_thr_e thr_sel;
    lisc_cur_e cur_sel;
    logic wake;
  } lisc_chan_s;

endpackage

/* lisc_chan_sense.sv */
// one channel's low-power sense selection and wake detection
`timescale 1ns/1ps
module lisc_chan_sense
  import lisc_pkg::*;
#(
  parameter bit PROGRAMMABLE = 1'b0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration
  input wire logic cmp_only,
  input wire logic thr_bit,
  input wire logic cur_bit,
  input wire logic battery_switch_config,
  // state
  input wire logic low_power_state,
  input wire logic lp_tick,
  input wire logic comp_in,
  // result
  output lisc_chan_s sense
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic wake_q;

  // comparator output is asynchronous
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= comp_in;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      last_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (!low_power_state)
    begin
      last_q <= sync2_q;
      wake_q <= 1'b0;
    end
    else if (lp_tick)
    begin
      last_q <= sync2_q;
      wake_q <= sense.cmp_active && (sync2_q != last_q);
    end
    else
    begin
      wake_q <= 1'b0;
    end
  end

  always_comb
  begin
    sense.wake = wake_q;
    sense.cmp_active = low_power_state;
    if (PROGRAMMABLE && battery_switch_config)
      sense.thr_sel = LISC_THR_FIXED_BATT;
    else if (thr_bit)
      sense.thr_sel = LISC_THR_NORMAL;
    else
      sense.thr_sel = LISC_THR_DELTA;
    if (!low_power_state || cmp_only)
      sense.cur_sel = LISC_CUR_NONE;
    else if (cur_bit)
      sense.cur_sel = LISC_CUR_WETTING;
    else
      sense.cur_sel = LISC_CUR_NORMAL;
  end

endmodule // lisc_chan_sense

/* lisc_regs.sv */
// spi-reached low-power input sense configuration registers
`timescale 1ns/1ps
// What this block does
// - comparator-only ground channel: comparator on, no current in low power
// - comparator-only channel wakes device when its input changes state
// - ground comparator-only register at 0x13, bits 13..0, reset zero
// - programmable ground-type channel, threshold bit 0: delta threshold
// - programmable ground-type channel, threshold bit 1: normal threshold
// - programmable battery-type channel always uses fixed 4.0V threshold
// - programmable threshold register at 0x14, bits 7..0, reset zero
// - ground channel threshold bit 0 selects delta threshold
// - ground channel threshold bit 1 selects normal threshold
// - ground threshold register at 0x15, bits 13..0, reset zero
// - polling bit 0: normal polling current, 2.2 or 1.0 mA
// - each programmable channel has its own polling current bit
// - polling bit 1: wetting current level used in low power
// - programmable polling current register at 0x16, bits 7..0, reset zero
module lisc_regs
  import lisc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // decoded spi frame from the shift logic
  input wire logic frame_valid,
  input wire logic [LISC_FRAME_W-1:0] frame_in,
  // status merged into every reply
  input wire logic fault_status,
  input wire logic interrupt_pending_flag,
  // reply word
  output logic [LISC_DATA_W-1:0] reply_q,
  output logic reply_hit_q,
  // device state
  input wire logic low_power_state,
  input wire logic lp_tick,
  input wire logic [LISC_PROG_CH-1:0] battery_switch_config,
  input wire logic [LISC_GND_CH-1:0] ground_switch_channels,
  input wire logic [LISC_PROG_CH-1:0] programmable_channels,
  // per-channel sense controls
  output lisc_chan_s [LISC_GND_CH-1:0] gnd_sense,
  output lisc_chan_s [LISC_PROG_CH-1:0] prog_sense,
  output logic wake_request
);

  logic [LISC_GND_CH-1:0] gnd_cmp_only_q;
  logic [LISC_PROG_CH-1:0] prog_thr_q;
  logic [LISC_GND_CH-1:0] gnd_thr_q;
  logic [LISC_PROG_CH-1:0] prog_cur_q;
  logic [LISC_ADDR_W-1:0] addr;
  logic wr;
  logic [LISC_DATA_W-1:0] wdata;
  logic [LISC_RDATA_W-1:0] rdata;
  logic hit;
  logic [LISC_GND_CH-1:0] gnd_wake;
  logic [LISC_PROG_CH-1:0] prog_wake;

  assign addr = frame_in[LISC_ADDR_MSB:LISC_ADDR_LSB];
  assign wr = frame_in[LISC_RW_BIT];
  assign wdata = frame_in[LISC_DATA_W-1:0];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gnd_cmp_only_q <= LISC_GND_RESET;
    else if (frame_valid && wr && addr == LISC_ADDR_GND_CMP_ONLY)
      gnd_cmp_only_q <= wdata[LISC_GND_CH-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      prog_thr_q <= LISC_PROG_RESET;
    else if (frame_valid && wr && addr == LISC_ADDR_PROG_LP_THR)
      prog_thr_q <= wdata[LISC_PROG_CH-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gnd_thr_q <= LISC_GND_RESET;
    else if (frame_valid && wr && addr == LISC_ADDR_GND_LP_THR)
      gnd_thr_q <= wdata[LISC_GND_CH-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      prog_cur_q <= LISC_PROG_RESET;
    else if (frame_valid && wr && addr == LISC_ADDR_PROG_POLL_CUR)
      prog_cur_q <= wdata[LISC_PROG_CH-1:0];
  end

  // read mux; unused bits read zero
  always_comb
  begin
    rdata = '0;
    hit = 1'b1;
    case (addr)
      LISC_ADDR_GND_CMP_ONLY: rdata[LISC_GND_CH-1:0] = gnd_cmp_only_q;
      LISC_ADDR_PROG_LP_THR: rdata[LISC_PROG_CH-1:0] = prog_thr_q;
      LISC_ADDR_GND_LP_THR: rdata[LISC_GND_CH-1:0] = gnd_thr_q;
      LISC_ADDR_PROG_POLL_CUR: rdata[LISC_PROG_CH-1:0] = prog_cur_q;
      default: hit = 1'b0;
    endcase
  end

  // reply: fault, flag, data
  // reply shows value before a write in the same frame
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reply_q <= '0;
      reply_hit_q <= 1'b0;
    end
    else if (frame_valid)
    begin
      reply_q <= {fault_status, interrupt_pending_flag, rdata};
      reply_hit_q <= hit;
    end
  end

  // ground channels have no battery option and no current bit
  for (genvar g = 0; g < LISC_GND_CH; g++)
  begin : g_gnd
    lisc_chan_sense #(.PROGRAMMABLE(1'b0)) u_chan (
      .clock(clock),
      .rst(rst),
      .cmp_only(gnd_cmp_only_q[g]),
      .thr_bit(gnd_thr_q[g]),
      .cur_bit(1'b0),
      .battery_switch_config(1'b0),
      .low_power_state(low_power_state),
      .lp_tick(lp_tick),
      .comp_in(ground_switch_channels[g]),
      .sense(gnd_sense[g])
    );
    assign gnd_wake[g] = gnd_sense[g].wake && gnd_cmp_only_q[g];
  end

  for (genvar p = 0; p < LISC_PROG_CH; p++)
  begin : g_prog
    lisc_chan_sense #(.PROGRAMMABLE(1'b1)) u_chan (
      .clock(clock),
      .rst(rst),
      .cmp_only(1'b0),
      .thr_bit(prog_thr_q[p]),
      .cur_bit(prog_cur_q[p]),
      .battery_switch_config(battery_switch_config[p]),
      .low_power_state(low_power_state),
      .lp_tick(lp_tick),
      .comp_in(programmable_channels[p]),
      .sense(prog_sense[p])
    );
    assign prog_wake[p] = 1'b0;
  end

  assign wake_request = |gnd_wake | |prog_wake;

endmodule // lisc_regs

/* lisc_regs_checker.sv */
// assertion checker for the sense config register block
`timescale 1ns/1ps
module lisc_regs_checker
  import lisc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // frame and reply
  input wire logic frame_valid,
  input wire logic [LISC_FRAME_W-1:0] frame_in,
  input wire logic fault_status,
  input wire logic interrupt_pending_flag,
  input wire logic [LISC_DATA_W-1:0] reply_q,
  input wire logic reply_hit_q,
  // sense
  input wire logic low_power_state,
  input wire logic lp_tick,
  input wire logic [LISC_PROG_CH-1:0] battery_switch_config,
  input wire lisc_chan_s [LISC_GND_CH-1:0] gnd_sense,
  input wire lisc_chan_s [LISC_PROG_CH-1:0] prog_sense,
  input wire logic wake_request
);
  logic [6:0] ad;
  logic hit;
  assign ad = frame_in[31:25];
  assign hit = ad >= 7'h13 && ad <= 7'h16;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_hit_seen: assert property (frame_valid && hit |=> reply_hit_q)
    else $error("mapped frame not flagged");
  a_miss_empty: assert property (frame_valid && !hit
    |=> !reply_hit_q && reply_q[21:0] == 22'h000000)
    else $error("unmapped frame answered");
  a_fault_copy: assert property (frame_valid
    |=> reply_q[23] == $past(fault_status))
    else $error("fault bit wrong");
  a_flag_copy: assert property (frame_valid
    |=> reply_q[22] == $past(interrupt_pending_flag))
    else $error("flag bit wrong");
  a_reply_held: assert property (!frame_valid |=> $stable(reply_q))
    else $error("reply moved without frame");
  a_batt_fixed: assert property (low_power_state &&
    battery_switch_config[0] |-> prog_sense[0].thr_sel == LISC_THR_FIXED_BATT)
    else $error("battery channel threshold wrong");
  a_wake_tick: assert property (gnd_sense[0].wake |-> $past(lp_tick))
    else $error("wake without tick");
  a_wake_out: assert property (gnd_sense[0].wake |-> wake_request)
    else $error("wake not requested");
endmodule // lisc_regs_checker

/* lisc_host_model.sv */
// host model issuing spi frames to the register block
`timescale 1ns/1ps
module lisc_host_model
  import lisc_pkg::*;
(
  // clock
  input wire logic clock,
  // frame out
  output logic frame_valid,
  output logic [LISC_FRAME_W-1:0] frame_in,
  // reply in
  input wire logic [LISC_DATA_W-1:0] reply_q
);
  initial frame_valid = 1'b0;
  initial frame_in = '0;
  task automatic xfer(input logic [6:0] a, input logic w,
    input logic [23:0] d, output logic [23:0] r);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_in <= {a, w, d};
    @(posedge clock);
    frame_valid <= 1'b0;
    // released bus shows junk, not the old frame
    frame_in <= ~{a, w, d};
    #1 r = reply_q;
  endtask
endmodule // lisc_host_model

/* lisc_regs_test.sv */
// self-checking bench for the sense config register block
`timescale 1ns/1ps
module lisc_regs_test
  import lisc_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, fv, rh, wr, lp = 1'b0, tk = 1'b0;
  logic fs = 1'b1, fl = 1'b0, seen;
  logic [31:0] fi;
  logic [23:0] rq, rd;
  logic [7:0] bat = 8'h01, pc = 8'h00;
  logic [13:0] gc = 14'h0000;
  lisc_chan_s [13:0] gs;
  lisc_chan_s [7:0] ps;
  int miscompares = 0, checks_done = 0;
  logic [6:0] ads [4] = '{7'h13, 7'h14, 7'h15, 7'h16};
  logic [23:0] msk [4] = '{24'h003FFF, 24'h0000FF, 24'h003FFF, 24'h0000FF};
  always #5 clock = ~clock;
  lisc_host_model u_host (.clock(clock), .frame_valid(fv), .frame_in(fi),
    .reply_q(rq));
  lisc_regs u_dut (.clock(clock), .rst(rst), .frame_valid(fv),
    .frame_in(fi), .fault_status(fs), .interrupt_pending_flag(fl),
    .reply_q(rq), .reply_hit_q(rh), .low_power_state(lp), .lp_tick(tk),
    .battery_switch_config(bat), .ground_switch_channels(gc),
    .programmable_channels(pc), .gnd_sense(gs), .prog_sense(ps),
    .wake_request(wr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      u_host.xfer(ads[i], 1'b0, 24'h000000, rd);
      chk(rd, 24'h800000);
      u_host.xfer(ads[i], 1'b1, 24'hFFFFFF, rd);
      chk(rd, 24'h800000);
      u_host.xfer(ads[i], 1'b0, 24'h000000, rd);
      chk(rd, 24'h800000 | msk[i]);
      chk(rh, 1'b1);
    end
    fl <= 1'b1;
    fs <= 1'b0;
    u_host.xfer(7'h17, 1'b1, 24'hFFFFFF, rd);
    u_host.xfer(7'h12, 1'b0, 24'h000000, rd);
    chk(rd, 24'h400000);
    chk(rh, 1'b0);
    $display("register tests done");
    lp <= 1'b1;
    @(posedge clock);
    #1;
    chk(gs[0].cmp_active, 1'b1);
    chk(gs[0].cur_sel, LISC_CUR_NONE);
    chk(gs[0].thr_sel, LISC_THR_NORMAL);
    chk(ps[1].thr_sel, LISC_THR_NORMAL);
    chk(ps[1].cur_sel, LISC_CUR_WETTING);
    chk(ps[0].thr_sel, LISC_THR_FIXED_BATT);
    u_host.xfer(7'h14, 1'b1, 24'h000000, rd);
    u_host.xfer(7'h15, 1'b1, 24'h000000, rd);
    u_host.xfer(7'h16, 1'b1, 24'h000002, rd);
    chk(ps[1].thr_sel, LISC_THR_DELTA);
    chk(gs[0].thr_sel, LISC_THR_DELTA);
    chk(ps[1].cur_sel, LISC_CUR_WETTING);
    chk(ps[2].cur_sel, LISC_CUR_NORMAL);
    $display("sense tests done");
    seen = 1'b0;
    gc <= 14'h0001;
    repeat (3) @(posedge clock);
    tk <= 1'b1;
    @(posedge clock);
    tk <= 1'b0;
    repeat (4)
    begin
      #1 seen = seen | wr;
      @(posedge clock);
    end
    chk(seen, 1'b1);
    $display("wake test done");
    summarize();
  end
  // far above the roughly 60 cycles the tests need
  initial
  begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule // lisc_regs_test
bind lisc_regs lisc_regs_checker u_chk (.clock(clock), .rst(rst),
  .frame_valid(frame_valid), .frame_in(frame_in),
  .fault_status(fault_status), .reply_q(reply_q),
  .interrupt_pending_flag(interrupt_pending_flag),
  .reply_hit_q(reply_hit_q), .low_power_state(low_power_state),
  .lp_tick(lp_tick), .battery_switch_config(battery_switch_config),
  .gnd_sense(gnd_sense), .prog_sense(prog_sense),
  .wake_request(wake_request));
